// file: design/bpr_regs.svh
// Register offsets, field positions, reset values and timing counts of the register bank.
`ifndef BPR_REGS_SVH
`define BPR_REGS_SVH

`define BPR_ADDR_STATUS 4'h0
`define BPR_ADDR_OUTPUT 4'h1
`define BPR_ADDR_STATE 4'h2
`define BPR_ADDR_FUNCTION 4'h3
`define BPR_ADDR_SELECT 4'h4
`define BPR_ADDR_OL_THRESH 4'h5
`define BPR_ADDR_OL_DELAY 4'h6
`define BPR_ADDR_SC_CHARGE 4'h7
`define BPR_ADDR_SC_DISCHARGE 4'h8

`define BPR_ST_SHORT_DSG 0
`define BPR_ST_SHORT_CHG 1
`define BPR_ST_OVERCURRENT 2
`define BPR_ST_WATCHDOG 3
`define BPR_ST_SLEEP 4
`define BPR_ST_CLAMP 5

`define BPR_OUT_RELEASE 0
`define BPR_OUT_DSG 1
`define BPR_OUT_CHG 2
`define BPR_OUT_ZV_OFF 3
`define BPR_OUT_OD 4

`define BPR_STATE_SLEEP 0
`define BPR_STATE_SHIP 1
`define BPR_STATE_WD_DIS 2

`define BPR_FN_VMON 0
`define BPR_FN_PACK 1
`define BPR_FN_OL_OFF 2
`define BPR_FN_SCC_OFF 3
`define BPR_FN_SCD_OFF 4
`define BPR_FN_THERM 5

`define BPR_RST_OUTPUT 5'h00
`define BPR_RST_STATE 3'h0
`define BPR_RST_FUNCTION 6'h00
`define BPR_RST_SELECT 8'h00
`define BPR_RST_OL_THRESH 5'h00
`define BPR_RST_OL_DELAY 4'h0
`define BPR_RST_SC 8'h00

`define BPR_MCLK_MHZ 125
`define BPR_WDOG_TIMEOUT_US 500
`define BPR_TICKS_PER_MS 33
`define BPR_TICKS_PER_SC_STEP 2
`define BPR_STRAP_SETTLE 2'h3

`endif

// file: design/bpr_pkg.sv
// Types shared by the register bank modules.
package bpr_pkg;
  typedef enum logic [0:0] {
    BPR_REL_IDLE,
    BPR_REL_ARMED
  } bpr_release_state_type;
endpackage

// file: design/bpr_sync.sv
// Two flip-flop synchroniser for a group of level signals.
`timescale 1ns/1ps
module bpr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage, so metastability never reaches logic.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // bpr_sync

// file: design/bpr_link_port.sv
// Link-clock side of the register access port with a toggle handshake to the logic clock.
`timescale 1ns/1ps
module bpr_link_port (
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic [3:0] link_addr,
  input wire logic [7:0] link_wdata,
  output logic [7:0] link_rdata,
  output logic link_rvalid,
  output logic link_busy,
  output logic req_toggle,
  output logic req_write,
  output logic [3:0] req_addr,
  output logic [7:0] req_wdata,
  input wire logic ack_toggle,
  input wire logic [7:0] ack_rdata
);
  logic ack_sync;
  logic ack_seen;

  bpr_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .rst_b(link_rst_b),
    .d(ack_toggle),
    .q(ack_sync)
  );

  // A request is taken only while idle; its words stay still until the answer returns.
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      req_toggle <= 1'b0;
      req_write <= 1'b0;
      req_addr <= 4'h0;
      req_wdata <= 8'h00;
      link_busy <= 1'b0;
    end else if (!link_busy && (link_wr || link_rd)) begin
      req_toggle <= ~req_toggle;
      req_write <= link_wr;
      req_addr <= link_addr;
      req_wdata <= link_wdata;
      link_busy <= 1'b1;
    end else if (ack_sync != ack_seen) begin
      link_busy <= 1'b0;
    end
  end

  // The answer word is stable at the logic side when its toggle arrives here.
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      ack_seen <= 1'b0;
      link_rvalid <= 1'b0;
      link_rdata <= 8'h00;
    end else begin
      ack_seen <= ack_sync;
      link_rvalid <= (ack_sync != ack_seen) && !req_write;
      if ((ack_sync != ack_seen) && !req_write) begin
        link_rdata <= ack_rdata;
      end
    end
  end
endmodule // bpr_link_port

// file: design/bpr_register_bank.sv
// Configuration and status register bank of the battery protection front end.
`timescale 1ns/1ps
`include "bpr_regs.svh"

module bpr_register_bank #(
  parameter int WDOG_TIMEOUT_CYC = `BPR_WDOG_TIMEOUT_US * `BPR_MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic [3:0] link_addr,
  input wire logic [7:0] link_wdata,
  output logic [7:0] link_rdata,
  output logic link_rvalid,
  output logic link_busy,
  input wire logic watchdog_clock_in,
  input wire logic overload_cmp,
  input wire logic short_charge_cmp,
  input wire logic short_discharge_cmp,
  input wire logic zero_volt_clamp_in,
  input wire logic sleep_pin,
  input wire logic pack_supply_lost,
  input wire logic precharge_mode_strap,
  output logic host_alert_out_b,
  output logic discharge_fet_ctl,
  output logic charge_fet_ctl,
  output logic zero_volt_charge_fet,
  output logic open_drain_out_o,
  output logic open_drain_out_oe,
  output logic ship_mode,
  output logic voltage_monitor_en,
  output logic monitor_out_grounded,
  output logic terminal_translate_en,
  output logic [1:0] series_element_sel,
  output logic [1:0] monitor_mode,
  output logic [3:0] balance_bypass_en,
  output logic thermistor_power,
  output logic [4:0] overcurrent_threshold,
  output logic [3:0] short_charge_threshold,
  output logic [3:0] short_discharge_threshold
);
  localparam int WDW = $clog2(WDOG_TIMEOUT_CYC + 1);
  localparam logic [WDW-1:0] WDOG_LIMIT = WDW'(WDOG_TIMEOUT_CYC);

  // Programmable delay in watchdog clock ticks; overload steps 2 ms from 1 ms, shorts 61 us.
  function automatic logic [10:0] delay_ticks(input logic is_overload, input logic [3:0] code);
    logic [10:0] ticks;
    ticks = 11'h000;
    if (is_overload) begin
      ticks = 11'((2 * code + 1) * `BPR_TICKS_PER_MS);
    end else begin
      ticks = 11'(code * `BPR_TICKS_PER_SC_STEP);
    end
    return ticks;
  endfunction

  logic req_toggle;
  logic req_write;
  logic [3:0] req_addr;
  logic [7:0] req_wdata;
  logic ack_toggle;
  logic [7:0] ack_rdata;
  logic req_sync;
  logic req_seen;
  logic req_new;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] pins_q;
  logic wdi_q;
  logic wdi_prev;
  logic tick;
  logic [4:0] output_drive_control;
  logic [2:0] power_state_control;
  logic [5:0] function_enable_control;
  logic [7:0] monitor_balance_select;
  logic [4:0] overload_threshold;
  logic [3:0] overload_delay;
  logic [7:0] charge_short_config;
  logic [7:0] discharge_short_config;
  logic [7:0] fault_status_flags;
  logic sleeping;
  logic [2:0] qual;
  logic [2:0] trip;
  logic [10:0] limit [3];
  logic [10:0] dly_cnt [3];
  logic [2:0] fault_latch;
  logic wdog_fault;
  logic [WDW-1:0] wdog_cnt;
  logic release_pulse;
  bpr_pkg::bpr_release_state_type rel_state;
  bpr_pkg::bpr_release_state_type next_rel_state;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic any_fault;
  logic new_fault;

  bpr_link_port u_link_port (
    .link_clk(link_clk),
    .link_rst_b(link_rst_b),
    .link_wr(link_wr),
    .link_rd(link_rd),
    .link_addr(link_addr),
    .link_wdata(link_wdata),
    .link_rdata(link_rdata),
    .link_rvalid(link_rvalid),
    .link_busy(link_busy),
    .req_toggle(req_toggle),
    .req_write(req_write),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .ack_toggle(ack_toggle),
    .ack_rdata(ack_rdata)
  );

  bpr_sync #(.WIDTH(1)) u_req_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .d(req_toggle),
    .q(req_sync)
  );

  // All analog comparator and pin levels arrive unsynchronised.
  bpr_sync #(.WIDTH(8)) u_pin_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .d({precharge_mode_strap, pack_supply_lost, sleep_pin, zero_volt_clamp_in,
        short_discharge_cmp, short_charge_cmp, overload_cmp, watchdog_clock_in}),
    .q(pins_q)
  );

  // The request words are steady by the time the synchronised toggle changes.
  assign req_new = req_sync ^ req_seen;
  assign wr_hit = req_new && req_write;
  assign rd_hit = req_new && !req_write;
  assign wdi_q = pins_q[0];
  assign tick = wdi_q && !wdi_prev;
  assign sleeping = power_state_control[`BPR_STATE_SLEEP] || pins_q[5];
  assign any_fault = |fault_latch || wdog_fault;

  // Qualified comparators: index 0 discharge short, 1 charge short, 2 overload.
  assign qual[0] = pins_q[3] && !function_enable_control[`BPR_FN_SCD_OFF] && !sleeping;
  assign qual[1] = pins_q[2] && !function_enable_control[`BPR_FN_SCC_OFF] && !sleeping;
  assign qual[2] = pins_q[1] && !function_enable_control[`BPR_FN_OL_OFF] && !sleeping;
  assign limit[0] = delay_ticks(1'b0, discharge_short_config[7:4]);
  assign limit[1] = delay_ticks(1'b0, charge_short_config[7:4]);
  assign limit[2] = delay_ticks(1'b1, overload_delay);

  // Status view: live condition or a held fault; spare bits stay zero.
  always_comb begin
    fault_status_flags = 8'h00;
    fault_status_flags[`BPR_ST_SHORT_DSG] = qual[0] || fault_latch[0];
    fault_status_flags[`BPR_ST_SHORT_CHG] = qual[1] || fault_latch[1];
    fault_status_flags[`BPR_ST_OVERCURRENT] = qual[2] || fault_latch[2];
    fault_status_flags[`BPR_ST_WATCHDOG] = wdog_fault;
    fault_status_flags[`BPR_ST_SLEEP] = sleeping;
    fault_status_flags[`BPR_ST_CLAMP] = pins_q[4];
  end

  // Logic-clock half of the handshake: one access per toggle, answer word held until the next.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_seen <= 1'b0;
      ack_toggle <= 1'b0;
      ack_rdata <= 8'h00;
    end else if (req_new) begin
      req_seen <= req_sync;
      ack_toggle <= ~ack_toggle;
      ack_rdata <= 8'h00;
      if (!req_write && !sleeping) begin
        case (req_addr)
          `BPR_ADDR_STATUS: ack_rdata <= fault_status_flags;
          `BPR_ADDR_OUTPUT: ack_rdata <= {3'h0, output_drive_control};
          `BPR_ADDR_STATE: ack_rdata <= {5'h00, power_state_control};
          `BPR_ADDR_FUNCTION: ack_rdata <= {2'h0, function_enable_control};
          `BPR_ADDR_SELECT: ack_rdata <= monitor_balance_select;
          `BPR_ADDR_OL_THRESH: ack_rdata <= {3'h0, overload_threshold};
          `BPR_ADDR_OL_DELAY: ack_rdata <= {4'h0, overload_delay};
          `BPR_ADDR_SC_CHARGE: ack_rdata <= charge_short_config;
          `BPR_ADDR_SC_DISCHARGE: ack_rdata <= discharge_short_config;
          default: ack_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Output control; the charge bit takes the strap level once it has settled after reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      output_drive_control <= `BPR_RST_OUTPUT;
    end else if (wr_hit && req_addr == `BPR_ADDR_OUTPUT) begin
      output_drive_control <= req_wdata[4:0];
    end else if (!strap_done && strap_cnt == `BPR_STRAP_SETTLE) begin
      output_drive_control[`BPR_OUT_CHG] <= pins_q[7];
    end
  end

  // Strap settle counter: the synchroniser needs two edges before its output is real.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      strap_done <= (strap_cnt == `BPR_STRAP_SETTLE);
    end
  end

  // Plain configuration registers; writes during sleep are kept for after wake-up.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      power_state_control <= `BPR_RST_STATE;
      function_enable_control <= `BPR_RST_FUNCTION;
      monitor_balance_select <= `BPR_RST_SELECT;
      overload_threshold <= `BPR_RST_OL_THRESH;
      overload_delay <= `BPR_RST_OL_DELAY;
      charge_short_config <= `BPR_RST_SC;
      discharge_short_config <= `BPR_RST_SC;
    end else if (wr_hit) begin
      case (req_addr)
        `BPR_ADDR_STATE: power_state_control <= req_wdata[2:0];
        `BPR_ADDR_FUNCTION: function_enable_control <= req_wdata[5:0];
        `BPR_ADDR_SELECT: monitor_balance_select <= req_wdata;
        `BPR_ADDR_OL_THRESH: overload_threshold <= req_wdata[4:0];
        `BPR_ADDR_OL_DELAY: overload_delay <= req_wdata[3:0];
        `BPR_ADDR_SC_CHARGE: charge_short_config <= req_wdata;
        `BPR_ADDR_SC_DISCHARGE: discharge_short_config <= req_wdata;
        default: power_state_control <= power_state_control;
      endcase
    end
  end

  // Release sequence: a 1 written over a 0 arms it, the following 0 fires it.
  always_comb begin
    next_rel_state = rel_state;
    case (rel_state)
      bpr_pkg::BPR_REL_IDLE: begin
        if (wr_hit && req_addr == `BPR_ADDR_OUTPUT && req_wdata[`BPR_OUT_RELEASE]
            && !output_drive_control[`BPR_OUT_RELEASE]) begin
          next_rel_state = bpr_pkg::BPR_REL_ARMED;
        end
      end
      bpr_pkg::BPR_REL_ARMED: begin
        if (wr_hit && req_addr == `BPR_ADDR_OUTPUT && !req_wdata[`BPR_OUT_RELEASE]) begin
          next_rel_state = bpr_pkg::BPR_REL_IDLE;
        end
      end
      default: next_rel_state = bpr_pkg::BPR_REL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rel_state <= bpr_pkg::BPR_REL_IDLE;
      release_pulse <= 1'b0;
    end else begin
      rel_state <= next_rel_state;
      release_pulse <= (rel_state == bpr_pkg::BPR_REL_ARMED)
                       && (next_rel_state == bpr_pkg::BPR_REL_IDLE);
    end
  end

  // Blanking delays run on watchdog ticks, so a dead watchdog clock also stops them.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdi_prev <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        dly_cnt[i] <= 11'h000;
      end
    end else begin
      wdi_prev <= wdi_q;
      for (int i = 0; i < 3; i++) begin
        if (!qual[i]) begin
          dly_cnt[i] <= 11'h000;
        end else if (tick && dly_cnt[i] < limit[i]) begin
          dly_cnt[i] <= dly_cnt[i] + 11'h001;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      trip[i] = qual[i] && (dly_cnt[i] >= limit[i]);
    end
  end

  // Fault latches; a trip in the release cycle survives the release.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_latch <= 3'h0;
    end else begin
      fault_latch <= trip | (fault_latch & {3{!release_pulse}});
    end
  end

  // Watchdog: count logic clocks between watchdog edges while monitoring is on.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_cnt <= '0;
      wdog_fault <= 1'b0;
    end else begin
      if (tick || power_state_control[`BPR_STATE_WD_DIS] || sleeping) begin
        wdog_cnt <= '0;
      end else if (wdog_cnt < WDOG_LIMIT) begin
        wdog_cnt <= wdog_cnt + 1'b1;
      end
      if (wdog_cnt >= WDOG_LIMIT && !power_state_control[`BPR_STATE_WD_DIS] && !sleeping) begin
        wdog_fault <= 1'b1;
      end else if (release_pulse) begin
        wdog_fault <= 1'b0;
      end
    end
  end

  assign new_fault = (|(trip & ~fault_latch)) || (wdog_cnt >= WDOG_LIMIT && !wdog_fault
                     && !power_state_control[`BPR_STATE_WD_DIS] && !sleeping);

  // Alert is active low; a new fault wins over a status read in the same cycle.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      host_alert_out_b <= 1'b1;
    end else if (new_fault) begin
      host_alert_out_b <= 1'b0;
    end else if (rd_hit && req_addr == `BPR_ADDR_STATUS && !sleeping) begin
      host_alert_out_b <= 1'b1;
    end
  end

  // FET and pin drive; sleep and held faults force the three FET drivers off, sleep also the open drain
  // and thermistor power. Turning the FETs off when monitoring is disabled is left to the host.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      discharge_fet_ctl <= 1'b0;
      charge_fet_ctl <= 1'b0;
      zero_volt_charge_fet <= 1'b0;
      open_drain_out_o <= 1'b0;
      open_drain_out_oe <= 1'b0;
      ship_mode <= 1'b0;
      thermistor_power <= 1'b0;
    end else begin
      discharge_fet_ctl <= output_drive_control[`BPR_OUT_DSG] && !any_fault && !sleeping;
      charge_fet_ctl <= output_drive_control[`BPR_OUT_CHG] && !any_fault && !sleeping;
      zero_volt_charge_fet <= !output_drive_control[`BPR_OUT_ZV_OFF] && !any_fault
                              && !sleeping;
      open_drain_out_o <= 1'b0;
      open_drain_out_oe <= output_drive_control[`BPR_OUT_OD] && !sleeping;
      ship_mode <= power_state_control[`BPR_STATE_SHIP] && pins_q[6];
      thermistor_power <= function_enable_control[`BPR_FN_THERM] && !sleeping;
    end
  end

  // Monitor and balance controls; translation stops in sleep, settings are kept.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      voltage_monitor_en <= 1'b0;
      monitor_out_grounded <= 1'b1;
      terminal_translate_en <= 1'b0;
      series_element_sel <= 2'h0;
      monitor_mode <= 2'h0;
      balance_bypass_en <= 4'h0;
      overcurrent_threshold <= 5'h00;
      short_charge_threshold <= 4'h0;
      short_discharge_threshold <= 4'h0;
    end else begin
      voltage_monitor_en <= function_enable_control[`BPR_FN_VMON] && !sleeping;
      monitor_out_grounded <= !function_enable_control[`BPR_FN_VMON] || sleeping;
      terminal_translate_en <= function_enable_control[`BPR_FN_VMON]
                               && function_enable_control[`BPR_FN_PACK] && !sleeping;
      series_element_sel <= monitor_balance_select[1:0];
      monitor_mode <= monitor_balance_select[3:2];
      balance_bypass_en <= sleeping ? 4'h0 : monitor_balance_select[7:4];
      overcurrent_threshold <= overload_threshold;
      short_charge_threshold <= charge_short_config[3:0];
      short_discharge_threshold <= discharge_short_config[3:0];
    end
  end
endmodule // bpr_register_bank

// file: test/bpr_bank_checker.sv
// Port-level assertions for the battery protection register bank.
`timescale 1ns/1ps
module bpr_bank_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic link_rvalid,
  input wire logic link_busy,
  input wire logic sleep_pin,
  input wire logic pack_supply_lost,
  input wire logic discharge_fet_ctl,
  input wire logic charge_fet_ctl,
  input wire logic zero_volt_charge_fet,
  input wire logic open_drain_out_o,
  input wire logic open_drain_out_oe,
  input wire logic ship_mode,
  input wire logic voltage_monitor_en,
  input wire logic monitor_out_grounded,
  input wire logic thermistor_power,
  input wire logic [3:0] balance_bypass_en
);
  // The sleep pin passes a synchroniser, so six cycles of it leave ample margin.
  sleep_fets_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sleep_pin [*6] |-> !discharge_fet_ctl && !charge_fet_ctl && !zero_volt_charge_fet
      && !open_drain_out_oe) else $error("drive left on in sleep");
  sleep_features_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sleep_pin [*6] |-> !thermistor_power && !voltage_monitor_en && balance_bypass_en == 4'h0)
    else $error("feature left on in sleep");
  od_pull_only_a: assert property (@(posedge mclk) disable iff (!rst_b)
    open_drain_out_oe |-> !open_drain_out_o) else $error("open drain driven high");
  monitor_ground_a: assert property (@(posedge mclk) disable iff (!rst_b)
    voltage_monitor_en |-> !monitor_out_grounded) else $error("monitor grounded while on");
  ship_needs_loss_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !pack_supply_lost [*6] |-> !ship_mode) else $error("ship with supply present");
  // Link side: each request must be answered within a bounded number of cycles.
  read_answer_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    link_rd && !link_wr && !link_busy |=> link_busy ##[1:20] link_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    link_wr && !link_busy |=> link_busy ##[1:20] !link_busy) else $error("write stuck");
  rvalid_pulse_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    link_rvalid |-> !link_busy ##1 !link_rvalid) else $error("bad read answer pulse");
endmodule // bpr_bank_checker

bind bpr_register_bank bpr_bank_checker u_bpr_bank_checker (.mclk, .rst_b, .link_clk,
  .link_rst_b, .link_wr, .link_rd, .link_rvalid, .link_busy, .sleep_pin, .pack_supply_lost,
  .discharge_fet_ctl, .charge_fet_ctl, .zero_volt_charge_fet, .open_drain_out_o,
  .open_drain_out_oe, .ship_mode, .voltage_monitor_en, .monitor_out_grounded,
  .thermistor_power, .balance_bypass_en);

// file: test/bpr_host_model.sv
// Host-side model that issues single-byte requests on the link port.
`timescale 1ns/1ps
module bpr_host_model (
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic link_rvalid,
  input wire logic [7:0] link_rdata,
  output logic link_wr,
  output logic link_rd,
  output logic [3:0] link_addr,
  output logic [7:0] link_wdata
);
  // Lines start idle.
  initial begin
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_addr = 4'h0;
    link_wdata = 8'h00;
  end
  // Only one request is outstanding; released words carry their inverse so stale data shows.
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    q = 8'hxx;
    @(posedge link_clk);
    link_wr <= wr;
    link_rd <= !wr;
    link_addr <= a;
    link_wdata <= d;
    do @(posedge link_clk); while (link_busy !== 1'b0);
    link_wr <= 1'b0;
    link_rd <= 1'b0;
    link_addr <= ~a;
    link_wdata <= ~d;
    n = 0;
    do begin
      @(posedge link_clk);
      if (link_rvalid === 1'b1) q = link_rdata;
      n++;
    end while (link_busy !== 1'b0 && n < 40);
  endtask
endmodule // bpr_host_model

// file: test/tb_top.sv
// Self-checking bench for the battery protection register bank.
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_b, link_clk, link_rst_b, link_wr, link_rd, link_rvalid, link_busy;
  logic [3:0] link_addr;
  logic [7:0] link_wdata, link_rdata, pins, sel, thr;
  logic watchdog_clock_in, overload_cmp, short_charge_cmp, short_discharge_cmp;
  logic zero_volt_clamp_in, sleep_pin, pack_supply_lost, precharge_mode_strap;
  logic host_alert_out_b, discharge_fet_ctl, charge_fet_ctl, zero_volt_charge_fet;
  logic open_drain_out_o, open_drain_out_oe, ship_mode, voltage_monitor_en;
  logic monitor_out_grounded, terminal_translate_en, thermistor_power;
  logic [1:0] series_element_sel, monitor_mode;
  logic [3:0] balance_bypass_en, short_charge_threshold, short_discharge_threshold;
  logic [4:0] overcurrent_threshold;
  logic wd_run = 1'b1;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Write values for 0x1..0x8; 0x2 keeps watchdog monitoring on.
  logic [7:0] wval [1:8] = '{8'hff, 8'hfa, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] rval [1:8] = '{8'h1f, 8'h02, 8'h3f, 8'hff, 8'h1f, 8'h0f, 8'hff, 8'hff};
  // Outputs grouped so that one compare covers a whole drive state.
  assign pins = {discharge_fet_ctl, charge_fet_ctl, zero_volt_charge_fet, open_drain_out_oe,
    voltage_monitor_en, monitor_out_grounded, terminal_translate_en, thermistor_power};
  assign sel = {balance_bypass_en, monitor_mode, series_element_sel};
  assign thr = {short_charge_threshold, short_discharge_threshold};
  bpr_register_bank #(.WDOG_TIMEOUT_CYC(200)) u_bpr_register_bank (.mclk, .rst_b, .link_clk,
    .link_rst_b, .link_wr, .link_rd, .link_addr, .link_wdata, .link_rdata, .link_rvalid,
    .link_busy, .watchdog_clock_in, .overload_cmp, .short_charge_cmp, .short_discharge_cmp,
    .zero_volt_clamp_in, .sleep_pin, .pack_supply_lost, .precharge_mode_strap,
    .host_alert_out_b, .discharge_fet_ctl, .charge_fet_ctl, .zero_volt_charge_fet,
    .open_drain_out_o, .open_drain_out_oe, .ship_mode, .voltage_monitor_en,
    .monitor_out_grounded, .terminal_translate_en, .series_element_sel, .monitor_mode,
    .balance_bypass_en, .thermistor_power, .overcurrent_threshold, .short_charge_threshold,
    .short_discharge_threshold);
  bpr_host_model u_bpr_host_model (.link_clk, .link_busy, .link_rvalid, .link_rdata,
    .link_wr, .link_rd, .link_addr, .link_wdata);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // The odd offset keeps link edges from ever meeting logic clock edges.
  initial begin
    link_clk = 1'b0;
    #7.1;
    forever #15 link_clk = ~link_clk;
  end
  // Watchdog clock of 40 cycles per period, well inside the shortened timeout.
  initial begin
    watchdog_clock_in = 1'b0;
    forever begin
      repeat (20) @(posedge mclk);
      if (wd_run) watchdog_clock_in <= ~watchdog_clock_in;
    end
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_bpr_host_model.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_bpr_host_model.access(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), exp, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic results();
    $display("Checks made %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {rst_b, link_rst_b, overload_cmp, short_charge_cmp, short_discharge_cmp} = 5'h00;
    {zero_volt_clamp_in, sleep_pin, pack_supply_lost, precharge_mode_strap} = 4'h0;
    settle(5);
    rst_b <= 1'b1;
    link_rst_b <= 1'b1;
    settle(20);
    for (int a = 0; a <= 8; a++) begin
      rd(4'(a), 8'h00);
    end
    wr(4'hf, 8'h55);
    rd(4'hf, 8'h00);
    chk("reset pins", 8'h24, pins);
    $display("reset test done");
    wr(4'h0, 8'hff);
    for (int a = 1; a <= 8; a++) begin
      wr(4'(a), wval[a]);
      rd(4'(a), rval[a]);
    end
    rd(4'h0, 8'h00);
    settle(8);
    chk("pins", 8'hdb, pins);
    chk("thresholds", 8'hff, thr);
    chk("overload", 8'h1f, 8'(overcurrent_threshold));
    pack_supply_lost <= 1'b1;
    settle(8);
    chk("ship", 8'h01, 8'(ship_mode));
    pack_supply_lost <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, {4'(1 << c), 2'(c), 2'(c)});
      settle(4);
      chk("select", {4'(1 << c), 2'(c), 2'(c)}, sel);
    end
    $display("write test done");
    wr(4'h2, 8'h01);
    rd(4'h1, 8'h00);
    chk("sleep pins", 8'h04, pins);
    chk("sleep select", 8'h0f, sel);
    wr(4'h5, 8'h0a);
    wr(4'h2, 8'h00);
    rd(4'h5, 8'h0a);
    settle(1);
    sleep_pin <= 1'b1;
    settle(10);
    chk("pin sleep", 8'h04, pins);
    sleep_pin <= 1'b0;
    settle(10);
    chk("wake pins", 8'hdb, pins);
    $display("sleep test done");
    wr(4'h3, 8'h04);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h1, 8'h06);
    settle(1);
    {overload_cmp, short_charge_cmp, short_discharge_cmp, zero_volt_clamp_in} <= 4'hf;
    settle(10);
    chk("fault pins", 8'h04, pins);
    chk("alert", 8'h00, 8'(host_alert_out_b));
    {overload_cmp, short_charge_cmp, short_discharge_cmp} <= 3'h0;
    rd(4'h0, 8'h23);
    settle(4);
    chk("alert", 8'h01, 8'(host_alert_out_b));
    wr(4'h1, 8'h07);
    wr(4'h1, 8'h06);
    rd(4'h0, 8'h20);
    settle(1);
    zero_volt_clamp_in <= 1'b0;
    settle(4);
    chk("released pins", 8'he4, pins);
    // Overload sensing on, shorts off: the live compare shows long before its delay ends.
    wr(4'h3, 8'h18);
    settle(1);
    overload_cmp <= 1'b1;
    settle(4);
    rd(4'h0, 8'h04);
    settle(1);
    overload_cmp <= 1'b0;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h04);
    wd_run <= 1'b0;
    settle(300);
    rd(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    settle(300);
    chk("alert", 8'h00, 8'(host_alert_out_b));
    rd(4'h0, 8'h08);
    wd_run <= 1'b1;
    settle(60);
    wr(4'h1, 8'h01);
    wr(4'h1, 8'h00);
    rd(4'h0, 8'h00);
    $display("fault test done");
    // Second reset with the strap tied high: the charge bit must come up set.
    settle(1);
    {rst_b, link_rst_b, precharge_mode_strap} <= 3'h1;
    settle(5);
    {rst_b, link_rst_b} <= 2'h3;
    settle(20);
    rd(4'h1, 8'h04);
    chk("strap pins", 8'h64, pins);
    $display("strap test done");
    results();
  end
endmodule // tb_top
